// [aci_pkg.sv]
package aci_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [4:0]  REG_BASIC_CONTROL  = 5'h00;
   localparam logic [4:0]  REG_BASIC_STATUS   = 5'h01;
   localparam logic [4:0]  REG_ADVERT         = 5'h04;
   localparam logic [4:0]  REG_PARTNER        = 5'h05;
   localparam logic [4:0]  REG_EXPANSION      = 5'h06;
   localparam logic [4:0]  REG_STATUS_SUMMARY = 5'h10;
   localparam logic [4:0]  REG_PORT_CONTROL   = 5'h19;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTL_SPEED     = 13;
   localparam int CTL_AN_EN     = 12;
   localparam int CTL_ISOLATE   = 10;
   localparam int CTL_RESTART   = 9;
   localparam int CTL_DUPLEX    = 8;
   localparam int ABL_100FD     = 8;
   localparam int ABL_100HD     = 7;
   localparam int ABL_10FD      = 6;
   localparam int ABL_10HD      = 5;
   localparam int ABL_NEXT_PAGE = 15;
   localparam int ABL_RFAULT    = 13;
   localparam int PCR_AUTO_X    = 15;
   localparam int PCR_FORCE_X   = 14;

   // ------------------------------------------------------------
   // Reset and constant values
   // ------------------------------------------------------------
   localparam logic [15:0] ADVERT_RST      = 16'h01e1;
   localparam logic [15:0] PD_PARTNER_100  = 16'h0081;
   localparam logic [15:0] PD_PARTNER_10   = 16'h0021;
   localparam logic [15:0] STATUS_CONST    = 16'h7849;
   localparam logic [4:0]  ADDR_RST        = 5'h01;
   localparam logic [1:0]  STRAP_WAIT      = 2'h2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_KHZ         = 200000;
   localparam int unsigned BREAK_MS        = 1500;
   localparam int unsigned COMPLETE_MS     = 3000;
   localparam int unsigned XOVER_SLOT_MS   = 60;
   localparam int unsigned BREAK_CYC       = BREAK_MS * CLK_KHZ;
   localparam int unsigned COMPLETE_CYC    = COMPLETE_MS * CLK_KHZ;
   localparam int unsigned XOVER_SLOT_CYC  = XOVER_SLOT_MS * CLK_KHZ;

   typedef enum logic [2:0] {
      ACI_ST_BREAK,
      ACI_ST_ABILITY,
      ACI_ST_ACK,
      ACI_ST_GOOD,
      ACI_ST_FORCED
   } aci_state_t;

endpackage

// [aci_xover.sv]
module aci_xover #(
   parameter int unsigned P_SLOT_CYC = aci_pkg::XOVER_SLOT_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic auto_en,
   input  wire logic force_x,
   input  wire logic link_up,
   output logic      crossed
);

   logic [15:0] lfsr_q;
   logic [31:0] slot_q;

   // ------------------------------------------------------------
   // Random seed and slot timer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_q <= 16'h0001;
      end else if (ce) begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_q <= 32'h0000_0000;
      end else if (ce) begin
         slot_q <= (slot_q == P_SLOT_CYC - 1) ? 32'h0000_0000 : slot_q + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // Pair assignment
   // ------------------------------------------------------------
   // The pair choice is only re-rolled while no link is up, so a good link is never broken.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         crossed <= 1'b0;
      end else if (ce) begin
         if (force_x) begin
            crossed <= 1'b1;
         end else if (!auto_en) begin
            crossed <= 1'b0;
         end else if (!link_up && slot_q == P_SLOT_CYC - 1) begin
            crossed <= lfsr_q[0];
         end
      end
   end

endmodule

// [aci_autoneg.sv]
// What this block does
// - While negotiating, send advertisement register abilities in link pulse bursts.
// - Resolve common mode: 100 full, 100 half, 10 full, 10 half.
// - Without negotiation, control speed and duplex bits select mode; ignored otherwise.
// - Report resolved link speed in the status summary register.
// - Basic status shows constant abilities and live completion, fault, link.
// - Advertisement resets to all abilities; cleared bits stop being advertised.
// - Partner register captures code words; parallel detect loads 0081h or 0021h.
// - Both receivers' link status drives parallel detection of the technology.
// - Parallel detect gives selector 00001 and partner-able bit zero.
// - Parallel detect fault set when both links are good at once.
// - Expansion register reports fault, next-page support, page received, partner able.
// - Writing restart bit starts a new negotiation.
// - Losing link after negotiation resumes negotiation automatically.
// - Renegotiation silences the line for the break timer, then sends bursts.
// - Negotiation or parallel detect completes within about three seconds.
// - Auto crossover on after reset, set by port control, random seed.
// - Force crossover bit crosses pairs; no auto crossover in forced mode.
// - Strapped port address latched into port control at reset.
// - Strapped address zero isolates; a written address zero does not.
// - Isolate bit ignores transmit inputs, floats outputs, keeps management alive.
// - While isolated keep idles or link pulses and allow link bring-up.
module aci_autoneg #(
   parameter int unsigned P_BREAK_CYC    = aci_pkg::BREAK_CYC,
   parameter int unsigned P_COMPLETE_CYC = aci_pkg::COMPLETE_CYC,
   parameter int unsigned P_XOVER_CYC    = aci_pkg::XOVER_SLOT_CYC,
   parameter bit          P_LOCAL_NP     = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_wr,
   input  wire logic [15:0] mgmt_wdata,
   input  wire logic        mgmt_rd,
   output logic      [15:0] mgmt_rdata,
   output logic             mgmt_rvalid,
   input  wire logic [4:0]  strap_addr_pin,
   input  wire logic        strap_an_en_pin,
   input  wire logic        flp_rx_valid,
   input  wire logic [15:0] flp_rx_word,
   input  wire logic        link_ok_10,
   input  wire logic        link_ok_100,
   output logic             flp_tx_en,
   output logic      [15:0] flp_tx_word,
   output logic             link_pulse_en,
   output logic             line_data_en,
   output logic             speed_100,
   output logic             full_duplex,
   output logic             link_up,
   output logic             mdi_crossed,
   output logic             mii_out_en,
   output logic             mii_tx_accept,
   output logic      [4:0]  port_address
);

   aci_pkg::aci_state_t st_q, st_d;

   logic [4:0]  addr_s1_q, addr_s2_q;
   logic        an_s1_q, an_s2_q;
   logic [1:0]  init_q;
   logic        strap_done_q;
   logic        ctl_speed_q, ctl_an_q, ctl_iso_q, ctl_restart_q, ctl_dup_q, armed_q;
   logic [15:0] advert_q, partner_q;
   logic        auto_x_q, force_x_q;
   logic        res_100_q, res_fd_q, base_seen_q, partner_able_q, partner_np_q;
   logic        pd_fault_q, page_rx_q;
   logic [31:0] tmr_q;
   logic        an_eff, wr_ctl, rd_exp, good_link, pd_one, pd_both;
   logic [3:0]  common;

   assign an_eff    = ctl_an_q & armed_q;
   assign wr_ctl    = mgmt_wr && mgmt_addr == aci_pkg::REG_BASIC_CONTROL;
   assign rd_exp    = mgmt_rd && mgmt_addr == aci_pkg::REG_EXPANSION;
   assign good_link = res_100_q ? link_ok_100 : link_ok_10;
   assign pd_one    = link_ok_10 ^ link_ok_100;
   assign pd_both   = link_ok_10 & link_ok_100;
   assign common    = advert_q[aci_pkg::ABL_100FD:aci_pkg::ABL_10HD]
                      & flp_rx_word[aci_pkg::ABL_100FD:aci_pkg::ABL_10HD];

   // ------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_s1_q <= 5'h00;
         addr_s2_q <= 5'h00;
         an_s1_q   <= 1'b0;
         an_s2_q   <= 1'b0;
      end else if (ce) begin
         addr_s1_q <= strap_addr_pin;
         addr_s2_q <= addr_s1_q;
         an_s1_q   <= strap_an_en_pin;
         an_s2_q   <= an_s1_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         init_q       <= 2'h0;
         strap_done_q <= 1'b0;
      end else if (ce && !strap_done_q) begin
         init_q       <= init_q + 2'h1;
         strap_done_q <= init_q == aci_pkg::STRAP_WAIT;
      end
   end

   // ------------------------------------------------------------
   // Basic control register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_speed_q   <= 1'b1;
         ctl_an_q      <= 1'b1;
         ctl_iso_q     <= 1'b0;
         ctl_restart_q <= 1'b0;
         ctl_dup_q     <= 1'b1;
         armed_q       <= 1'b1;
      end else if (ce) begin
         if (!strap_done_q && init_q == aci_pkg::STRAP_WAIT) begin
            ctl_an_q  <= an_s2_q;
            armed_q   <= an_s2_q;
            ctl_iso_q <= addr_s2_q == 5'h00;
         end else if (wr_ctl) begin
            ctl_speed_q <= mgmt_wdata[aci_pkg::CTL_SPEED];
            ctl_an_q    <= mgmt_wdata[aci_pkg::CTL_AN_EN];
            ctl_iso_q   <= mgmt_wdata[aci_pkg::CTL_ISOLATE];
            ctl_dup_q   <= mgmt_wdata[aci_pkg::CTL_DUPLEX];
            if (!mgmt_wdata[aci_pkg::CTL_AN_EN]) begin
               armed_q <= 1'b1;
            end
         end
         if (wr_ctl && mgmt_wdata[aci_pkg::CTL_RESTART]) begin
            ctl_restart_q <= 1'b1;
         end else if (st_q == aci_pkg::ACI_ST_BREAK) begin
            ctl_restart_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Advertisement and port control registers
   // ------------------------------------------------------------
   // all abilities after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         advert_q <= aci_pkg::ADVERT_RST;
      end else if (ce && mgmt_wr && mgmt_addr == aci_pkg::REG_ADVERT) begin
         advert_q <= mgmt_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         auto_x_q     <= 1'b1;
         force_x_q    <= 1'b0;
         port_address <= aci_pkg::ADDR_RST;
      end else if (ce) begin
         if (!strap_done_q && init_q == aci_pkg::STRAP_WAIT) begin
            port_address <= addr_s2_q;
         end else if (mgmt_wr && mgmt_addr == aci_pkg::REG_PORT_CONTROL) begin
            auto_x_q     <= mgmt_wdata[aci_pkg::PCR_AUTO_X];
            force_x_q    <= mgmt_wdata[aci_pkg::PCR_FORCE_X];
            port_address <= mgmt_wdata[4:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Negotiation state machine
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         aci_pkg::ACI_ST_BREAK: begin
            if (tmr_q == P_BREAK_CYC - 1) begin
               st_d = aci_pkg::ACI_ST_ABILITY;
            end
         end
         aci_pkg::ACI_ST_ABILITY: begin
            if (ctl_restart_q) begin
               st_d = aci_pkg::ACI_ST_BREAK;
            end else if (flp_rx_valid && !base_seen_q) begin
               st_d = aci_pkg::ACI_ST_ACK;
            end else if (pd_one) begin
               st_d = aci_pkg::ACI_ST_GOOD;
            end else if (tmr_q == P_COMPLETE_CYC - 1) begin
               st_d = aci_pkg::ACI_ST_BREAK;
            end
         end
         aci_pkg::ACI_ST_ACK: begin
            if (ctl_restart_q || tmr_q == P_COMPLETE_CYC - 1) begin
               st_d = aci_pkg::ACI_ST_BREAK;
            end else if (good_link) begin
               st_d = aci_pkg::ACI_ST_GOOD;
            end
         end
         aci_pkg::ACI_ST_GOOD: begin
            if (ctl_restart_q || !good_link) begin
               st_d = aci_pkg::ACI_ST_BREAK;
            end
         end
         default: begin
            if (an_eff) begin
               st_d = aci_pkg::ACI_ST_BREAK;
            end
         end
      endcase
      if (!strap_done_q) begin
         st_d = st_q;
      end else if (!an_eff) begin
         st_d = aci_pkg::ACI_ST_FORCED;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= aci_pkg::ACI_ST_FORCED;
         tmr_q <= 32'h0000_0000;
      end else if (ce) begin
         st_q  <= st_d;
         tmr_q <= (st_d != st_q) ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------
   // Resolution and partner capture
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         res_100_q      <= 1'b0;
         res_fd_q       <= 1'b0;
         base_seen_q    <= 1'b0;
         partner_q      <= 16'h0000;
         partner_able_q <= 1'b0;
         partner_np_q   <= 1'b0;
      end else if (ce) begin
         if (st_q == aci_pkg::ACI_ST_BREAK) begin
            base_seen_q    <= 1'b0;
            partner_able_q <= 1'b0;
         end else if ((st_q == aci_pkg::ACI_ST_ABILITY || st_q == aci_pkg::ACI_ST_ACK)
                      && flp_rx_valid) begin
            partner_q      <= flp_rx_word;
            partner_able_q <= 1'b1;
            if (!base_seen_q) begin
               base_seen_q  <= 1'b1;
               partner_np_q <= flp_rx_word[aci_pkg::ABL_NEXT_PAGE];
               res_100_q    <= common[3] | common[2];
               res_fd_q     <= common[3] | (!common[2] & common[1]);
            end
         end else if (st_q == aci_pkg::ACI_ST_ABILITY && pd_one) begin
            partner_q      <= link_ok_100 ? aci_pkg::PD_PARTNER_100 : aci_pkg::PD_PARTNER_10;
            partner_able_q <= 1'b0;
            res_100_q      <= link_ok_100;
            res_fd_q       <= 1'b0;
         end
      end
   end

   // latching flags clear on read, set wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pd_fault_q <= 1'b0;
         page_rx_q  <= 1'b0;
      end else if (ce) begin
         if (st_q == aci_pkg::ACI_ST_ABILITY && pd_both && !flp_rx_valid) begin
            pd_fault_q <= 1'b1;
         end else if (rd_exp) begin
            pd_fault_q <= 1'b0;
         end
         if (flp_rx_valid && st_q != aci_pkg::ACI_ST_FORCED) begin
            page_rx_q <= 1'b1;
         end else if (rd_exp) begin
            page_rx_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Line and MII outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flp_tx_en     <= 1'b0;
         flp_tx_word   <= aci_pkg::ADVERT_RST;
         link_pulse_en <= 1'b0;
         line_data_en  <= 1'b0;
         speed_100     <= 1'b0;
         full_duplex   <= 1'b0;
         link_up       <= 1'b0;
         mii_out_en    <= 1'b0;
         mii_tx_accept <= 1'b0;
      end else if (ce) begin
         // bursts carry advertisement; silent during break
         flp_tx_en     <= st_q == aci_pkg::ACI_ST_ABILITY || st_q == aci_pkg::ACI_ST_ACK;
         flp_tx_word   <= advert_q;
         // idles and link pulses stay on while isolated
         link_pulse_en <= st_q == aci_pkg::ACI_ST_GOOD || st_q == aci_pkg::ACI_ST_FORCED;
         if (st_q == aci_pkg::ACI_ST_FORCED) begin
            speed_100   <= ctl_speed_q;
            full_duplex <= ctl_dup_q;
            link_up     <= ctl_speed_q ? link_ok_100 : link_ok_10;
         end else begin
            speed_100   <= res_100_q;
            full_duplex <= res_fd_q;
            link_up     <= st_q == aci_pkg::ACI_ST_GOOD && good_link;
         end
         // isolate floats outputs and ignores transmit data
         line_data_en  <= !ctl_iso_q && link_up;
         mii_out_en    <= !ctl_iso_q;
         mii_tx_accept <= !ctl_iso_q && link_up;
      end
   end

   // force crosses; no auto in forced mode
   aci_xover #(
      .P_SLOT_CYC (P_XOVER_CYC)
   ) u_xover (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .auto_en (auto_x_q && an_eff),
      .force_x (force_x_q),
      .link_up (link_up),
      .crossed (mdi_crossed)
   );

   // ------------------------------------------------------------
   // Management read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata  <= 16'h0000;
         mgmt_rvalid <= 1'b0;
      end else if (ce) begin
         mgmt_rvalid <= mgmt_rd;
         if (!mgmt_rd) begin
            mgmt_rdata <= 16'h0000;
         end else if (mgmt_addr == aci_pkg::REG_BASIC_CONTROL) begin
            mgmt_rdata <= {2'b00, ctl_speed_q, ctl_an_q, 1'b0, ctl_iso_q, ctl_restart_q,
                           ctl_dup_q, 8'h00};
         end else if (mgmt_addr == aci_pkg::REG_BASIC_STATUS) begin
            mgmt_rdata <= aci_pkg::STATUS_CONST
                          | {10'h000, st_q == aci_pkg::ACI_ST_GOOD,
                             partner_q[aci_pkg::ABL_RFAULT], 1'b0, link_up, 2'b00};
         end else if (mgmt_addr == aci_pkg::REG_ADVERT) begin
            mgmt_rdata <= advert_q;
         end else if (mgmt_addr == aci_pkg::REG_PARTNER) begin
            mgmt_rdata <= partner_q;
         end else if (mgmt_addr == aci_pkg::REG_EXPANSION) begin
            mgmt_rdata <= {11'h000, pd_fault_q, partner_np_q, P_LOCAL_NP, page_rx_q,
                           partner_able_q};
         end else if (mgmt_addr == aci_pkg::REG_STATUS_SUMMARY) begin
            mgmt_rdata <= {1'b0, mdi_crossed, 9'h000, st_q == aci_pkg::ACI_ST_GOOD, 1'b0,
                           full_duplex, !speed_100, link_up};
         end else if (mgmt_addr == aci_pkg::REG_PORT_CONTROL) begin
            mgmt_rdata <= {auto_x_q, force_x_q, 9'h000, port_address};
         end else begin
            mgmt_rdata <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_break_silent: assert property (ce && st_q == aci_pkg::ACI_ST_BREAK
      |=> !flp_tx_en && !link_pulse_en) else $error("line not silent in break");
   chk_priority_order: assert property (ce && st_q == aci_pkg::ACI_ST_ABILITY
      && st_d == aci_pkg::ACI_ST_ACK && common[3] |=> res_100_q && res_fd_q)
      else $error("100 full not chosen first");
   chk_forced_mode: assert property (ce && st_q == aci_pkg::ACI_ST_FORCED && !wr_ctl
      |=> speed_100 == ctl_speed_q && full_duplex == ctl_dup_q)
      else $error("forced speed or duplex wrong");
   chk_pd_partner: assert property (ce && st_q == aci_pkg::ACI_ST_ABILITY
      && st_d == aci_pkg::ACI_ST_GOOD |=> partner_q[4:0] == 5'h01 && !partner_able_q)
      else $error("parallel detect partner word wrong");
   chk_pd_fault: assert property (ce && st_q == aci_pkg::ACI_ST_ABILITY && pd_both
      && !flp_rx_valid |=> pd_fault_q) else $error("parallel detect fault missed");
   chk_restart_clear: assert property (ce && st_q == aci_pkg::ACI_ST_BREAK
      && !wr_ctl |=> !ctl_restart_q) else $error("restart bit did not clear");
   chk_link_loss: assert property (ce && st_q == aci_pkg::ACI_ST_GOOD && an_eff
      && !good_link |=> st_q == aci_pkg::ACI_ST_BREAK) else $error("no renegotiation on loss");
   chk_isolate_outputs: assert property (ce && ctl_iso_q
      |=> !mii_out_en && !mii_tx_accept) else $error("isolate did not float outputs");
   chk_force_cross: assert property (ce && force_x_q |=> mdi_crossed)
      else $error("forced crossover not applied");
   chk_break_exit: assert property (ce && st_q == aci_pkg::ACI_ST_BREAK && an_eff
      && tmr_q == P_BREAK_CYC - 1 |=> st_q == aci_pkg::ACI_ST_ABILITY ##1 flp_tx_en)
      else $error("break timer exit wrong");

   cov_an_good: cover property (st_q == aci_pkg::ACI_ST_ACK ##1 st_q == aci_pkg::ACI_ST_GOOD);
   cov_pd_good: cover property (st_q == aci_pkg::ACI_ST_ABILITY ##1 st_q == aci_pkg::ACI_ST_GOOD);
   cov_forced:  cover property (st_q == aci_pkg::ACI_ST_FORCED && link_up);
   cov_restart: cover property (st_q == aci_pkg::ACI_ST_GOOD ##1 st_q == aci_pkg::ACI_ST_BREAK);

endmodule

// [aci_link_partner.sv]
module aci_link_partner (
   input  wire logic        clk_sys,
   input  wire logic        flp_tx_en,
   input  wire logic        send_en,
   input  wire logic [15:0] word,
   output logic             flp_rx_valid,
   output logic      [15:0] flp_rx_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tx_q = 1'b0;
   initial flp_rx_valid = 1'b0;
   initial flp_rx_word = 16'h0000;
   // One code word per new burst; idle word toggles so no stale value reads as valid.
   always @(posedge clk_sys) begin
      tx_q <= flp_tx_en;
      flp_rx_valid <= send_en && flp_tx_en && !tx_q;
      flp_rx_word <= (send_en && flp_tx_en && !tx_q) ? word : ~flp_rx_word;
   end
endmodule

// [aci_autoneg_tb.sv]
module aci_autoneg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst_n = 1'b0, mgmt_wr = 1'b0, mgmt_rd = 1'b0;
   logic ok10 = 1'b0, ok100 = 1'b0, send = 1'b1, rvalid, rxv, flp_tx_en, link_pulse_en;
   logic speed_100, full_duplex, link_up, mii_out_en;
   logic an_pin = 1'b1, lde, txa;
   logic [4:0] addr = 5'h00, strap = 5'h01, port_address;
   logic [15:0] wdata = 16'h0000, lp_word = 16'h0021, adv, rxw, rdata, flp_tx_word, v;
   logic [1:0] e;
   int seed = 62, fails = 0, n_checks = 0;
   aci_autoneg #(.P_BREAK_CYC(50), .P_COMPLETE_CYC(200), .P_XOVER_CYC(16)) u_aci_autoneg (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .mgmt_addr(addr), .mgmt_wr(mgmt_wr),
      .mgmt_wdata(wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
      .strap_addr_pin(strap), .strap_an_en_pin(an_pin), .flp_rx_valid(rxv), .flp_rx_word(rxw),
      .link_ok_10(ok10), .link_ok_100(ok100), .flp_tx_en(flp_tx_en), .flp_tx_word(flp_tx_word),
      .link_pulse_en(link_pulse_en), .line_data_en(lde), .speed_100(speed_100),
      .full_duplex(full_duplex), .link_up(link_up), .mdi_crossed(), .mii_out_en(mii_out_en),
      .mii_tx_accept(txa), .port_address(port_address));
   aci_link_partner u_aci_link_partner (.clk_sys(clk_sys), .flp_tx_en(flp_tx_en),
      .send_en(send), .word(lp_word), .flp_rx_valid(rxv), .flp_rx_word(rxw));
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic conclude();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] x, logic [15:0] g);
      n_checks++;
      if (g !== x) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      mgmt_wr = 1'b1;
      @(negedge clk_sys);
      mgmt_wr = 1'b0;
   endtask
   task automatic rd(logic [4:0] a);
      @(negedge clk_sys);
      addr = a;
      mgmt_rd = 1'b1;
      @(negedge clk_sys);
      mgmt_rd = 1'b0;
      v = (rvalid === 1'b1) ? rdata : 16'hxxxx;
   endtask
   function automatic logic pick(int w);
      return (w == 0) ? flp_tx_en : (w == 1) ? link_up : mii_out_en;
   endfunction
   task automatic wt(int w, logic x);
      for (int i = 0; i < 3000 && pick(w) !== x; i++) @(negedge clk_sys);
      if (pick(w) !== x) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [1:0] res(logic [15:0] c);
      if (c[8]) return 2'b11;
      if (c[7]) return 2'b10;
      if (c[6]) return 2'b01;
      return 2'b00;
   endfunction
   initial begin
      strap = 5'($unsigned($random(seed))) | 5'h02;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      rd(aci_pkg::REG_ADVERT);
      chk("advert", aci_pkg::ADVERT_RST, v);
      rd(aci_pkg::REG_BASIC_STATUS);
      chk("status", aci_pkg::STATUS_CONST, v & aci_pkg::STATUS_CONST);
      rd(5'h1f);
      chk("unmapped", 16'h0000, v);
      chk("addr", {11'h000, strap}, {11'h000, port_address});
      for (int k = 0; k < 4; k++) begin
         adv = 16'h0021 | (16'($random(seed)) & 16'h01c0);
         lp_word = 16'h0021 | (16'($random(seed)) & 16'h01c0);
         send = (k < 3);
         ok10 = 1'b0;
         ok100 = 1'b0;
         wr(aci_pkg::REG_ADVERT, adv);
         wr(aci_pkg::REG_BASIC_CONTROL, 16'h1200);
         rd(aci_pkg::REG_BASIC_CONTROL);
         chk("restart", 16'h0000, v & 16'h0200);
         chk("silent", 16'h0000, {14'h0000, flp_tx_en, link_pulse_en});
         wt(0, 1'b1);
         chk("burst", adv, flp_tx_word);
         e = send ? res(adv & lp_word) : 2'b10;
         ok10 = !send;
         ok100 = !send;
         repeat (3) @(negedge clk_sys);
         ok100 = e[1];
         ok10 = !e[1];
         wt(1, 1'b1);
         chk("mode", {14'h0000, e}, {14'h0000, speed_100, full_duplex});
         @(negedge clk_sys);
         chk("data", 16'h0003, {14'h0000, lde, txa});
         rd(aci_pkg::REG_STATUS_SUMMARY);
         chk("summary", {13'h0000, e[0], !e[1], 1'b1}, v & 16'h0007);
         $display("test %0d done", k);
      end
      rd(aci_pkg::REG_PARTNER);
      chk("pd", aci_pkg::PD_PARTNER_100, v);
      rd(aci_pkg::REG_EXPANSION);
      chk("pd_fault", 16'h0010, v & 16'h0011);
      wr(aci_pkg::REG_BASIC_CONTROL, 16'h0500);
      wt(2, 1'b0);
      @(negedge clk_sys);
      chk("forced", 16'h0001, {14'h0000, speed_100, full_duplex});
      chk("iso", 16'h0000, {14'h0000, mii_out_en, txa});
      $display("test forced done");
      rst_n = 1'b0;
      strap = 5'h00;
      an_pin = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("strap0", 16'h0000, {11'h000, port_address});
      chk("iso0", 16'h0000, {15'h0000, mii_out_en});
      wr(aci_pkg::REG_BASIC_CONTROL, 16'h1000);
      repeat (2) @(negedge clk_sys);
      chk("armed", 16'h0001, {15'h0000, link_pulse_en});
      wr(aci_pkg::REG_BASIC_CONTROL, 16'h0000);
      wr(aci_pkg::REG_BASIC_CONTROL, 16'h1000);
      wr(aci_pkg::REG_PORT_CONTROL, 16'h4000);
      rd(aci_pkg::REG_STATUS_SUMMARY);
      chk("cross", 16'h4000, v & 16'h4000);
      chk("an_on", 16'h0000, {15'h0000, link_pulse_en});
      chk("wr0", 16'h0001, {15'h0000, mii_out_en});
      $display("test strap done");
      conclude();
   end
endmodule
